// File: design/tib_pkg.sv
// Constants shared by the tuner bus bridge: register map, fields, bit timing.
// Assumes a 40 MHz core clock and a separate, faster link clock.
package tib_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADR_TGT = 8'h55;
  localparam logic [7:0] ADR_DAT0 = 8'h56;
  localparam logic [7:0] ADR_DAT7 = 8'h5d;
  localparam logic [7:0] ADR_CTL = 8'h5e;
  localparam logic [7:0] ADR_RAW = 8'hf9;
  localparam logic [7:0] ADR_MST = 8'hfb;
  localparam logic [7:0] ADR_MSK = 8'hfd;
  localparam logic [7:0] ADR_CLR = 8'hff;

  // ==========================================================
  // Field positions and reset values
  localparam int TGT_DIR = 0;
  localparam int CTL_CNT_HI = 7;
  localparam int CTL_CNT_LO = 5;
  localparam int CTL_GO = 2;
  localparam int CTL_SUB = 1;
  localparam int CTL_FAST = 0;
  localparam int ST_DONE = 0;
  localparam int ST_ERR = 1;
  localparam int NBYTES = 8;
  localparam logic [7:0] REG_RST = 8'h00;

  // ==========================================================
  // Bit timing: quarter bit periods on the link clock, rounded up
  localparam int LINK_HZ = 83_333_333;
  localparam int RATE_STD_KBPS = 100;
  localparam int RATE_FAST_KBPS = 400;
  localparam logic [7:0] QTR_STD =
    8'((LINK_HZ + 4000 * RATE_STD_KBPS - 1) / (4000 * RATE_STD_KBPS));
  localparam logic [7:0] QTR_FAST =
    8'((LINK_HZ + 4000 * RATE_FAST_KBPS - 1) / (4000 * RATE_FAST_KBPS));

  typedef enum logic [1:0] {TIB_CMD_START, TIB_CMD_BITS, TIB_CMD_STOP} tib_cmd_t;

endpackage : tib_pkg

// File: design/tib_bit_eng.sv
// Bit engine of the tuner bus: start, nine clocked bits, stop.
// Runs on the link clock; pins are open drain with pull-ups outside.
module tib_bit_eng
  import tib_pkg::*;
#(
  parameter logic [7:0] QTR_STD_P = QTR_STD,
  parameter logic [7:0] QTR_FAST_P = QTR_FAST
) (
  // Link clock and reset
  input wire logic clk_link,
  input wire logic lnrst,
  // Command
  input wire logic cmd_valid,
  input wire tib_cmd_t cmd,
  input wire logic [7:0] tx_byte,
  input wire logic ack_bit,
  input wire logic fast,
  output logic ready,
  output logic done,
  output logic [7:0] rx_byte,
  output logic rx_ack,
  // Pins
  input wire logic sda_in,
  output logic scl_oe_n,
  output logic sda_oe_n
);

  typedef enum logic [1:0] {E_IDLE, E_START, E_BITS, E_STOP} tib_est_t;
  typedef struct packed {
    tib_est_t st;
    logic [1:0] q;
    logic [3:0] n;
    logic [7:0] div;
    logic [8:0] tx;
    logic [8:0] rx;
    logic scl_low;
    logic sda_low;
    logic done;
    logic s1;
    logic s2;
  } tib_eng_t;

  tib_eng_t eng_r, eng_nxt;
  logic [7:0] qtr;
  logic tick;

  always_comb begin
    qtr = fast ? QTR_FAST_P : QTR_STD_P;
    tick = (eng_r.div == 8'h00);
    eng_nxt = eng_r;
    eng_nxt.done = 1'b0;
    eng_nxt.s1 = sda_in;
    eng_nxt.s2 = eng_r.s1;
    if (eng_r.st != E_IDLE) begin
      eng_nxt.div = tick ? qtr - 8'h01 : eng_r.div - 8'h01;
      if (tick) begin
        eng_nxt.q = eng_r.q + 2'h1;
      end
    end
    unique case (eng_r.st)
      E_IDLE: begin
        if (cmd_valid) begin
          eng_nxt.st = (cmd == TIB_CMD_START) ? E_START :
                       (cmd == TIB_CMD_STOP) ? E_STOP : E_BITS;
          eng_nxt.q = 2'h0;
          eng_nxt.n = 4'h0;
          eng_nxt.div = qtr - 8'h01;
          eng_nxt.tx = {tx_byte, ack_bit};
        end
      end
      // Three idle quarters first give the bus free time after a stop
      E_START: begin
        if (tick && eng_r.q == 2'h0) begin
          eng_nxt.sda_low = 1'b0;
        end
        if (tick && eng_r.q == 2'h2) begin
          eng_nxt.sda_low = 1'b1;
        end
        if (tick && eng_r.q == 2'h3) begin
          eng_nxt.scl_low = 1'b1;
          eng_nxt.st = E_IDLE;
          eng_nxt.done = 1'b1;
        end
      end
      E_BITS: begin
        if (tick && eng_r.q == 2'h0) begin
          eng_nxt.sda_low = ~eng_r.tx[8];
        end
        if (tick && eng_r.q == 2'h1) begin
          eng_nxt.scl_low = 1'b0;
        end
        if (tick && eng_r.q == 2'h2) begin
          eng_nxt.rx = {eng_r.rx[7:0], eng_r.s2};
        end
        if (tick && eng_r.q == 2'h3) begin
          eng_nxt.scl_low = 1'b1;
          eng_nxt.tx = {eng_r.tx[7:0], 1'b1};
          eng_nxt.n = 4'(eng_r.n + 4'h1);
          if (eng_r.n == 4'h8) begin
            eng_nxt.st = E_IDLE;
            eng_nxt.done = 1'b1;
          end
        end
      end
      E_STOP: begin
        if (tick && eng_r.q == 2'h0) begin
          eng_nxt.sda_low = 1'b1;
        end
        if (tick && eng_r.q == 2'h1) begin
          eng_nxt.scl_low = 1'b0;
        end
        if (tick && eng_r.q == 2'h2) begin
          eng_nxt.sda_low = 1'b0;
        end
        if (tick && eng_r.q == 2'h3) begin
          eng_nxt.st = E_IDLE;
          eng_nxt.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_link) begin
    if (!lnrst) begin
      eng_r <= '0;
    end else begin
      eng_r <= eng_nxt;
    end
  end

  assign ready = (eng_r.st == E_IDLE);
  assign done = eng_r.done;
  assign rx_byte = eng_r.rx[8:1];
  assign rx_ack = eng_r.rx[0];
  assign scl_oe_n = ~eng_r.scl_low;
  assign sda_oe_n = ~eng_r.sda_low;

  AST_SDA_ONLY_SCL_LOW: assert property (@(posedge clk_link) disable iff (!lnrst)
    $changed(eng_r.sda_low) && !$past(eng_r.scl_low) |-> $past(eng_r.st) != E_BITS)
    else $error("Data moved while clock high inside a byte");
  AST_NINE_BITS: assert property (@(posedge clk_link) disable iff (!lnrst)
    eng_r.st == E_BITS |-> eng_r.n <= 4'h8)
    else $error("Byte ran past nine bits");

endmodule : tib_bit_eng

// File: design/tib_bridge.sv
// Tuner bus bridge: staging registers on the core clock, transaction
// sequencer on the link clock, driving an open-drain two-wire bus.
// Assumes pull-ups on both lines and the tuner as the only slave.
module tib_bridge
  import tib_pkg::*;
(
  // Core clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link clock
  input wire logic clk_link,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Interrupt
  output logic host_irq_out,
  // Tuner bus pins
  output logic tuner_bus_clock_line_out,
  output logic tuner_bus_clock_line_oe_n,
  input wire logic tuner_bus_data_line_in,
  output logic tuner_bus_data_line_out,
  output logic tuner_bus_data_line_oe_n
);

  // ==========================================================
  // State types

  typedef enum logic [2:0] {Q_IDLE, Q_START, Q_ADDR, Q_DATA, Q_STOP} tib_seq_t;

  typedef struct packed {
    logic [7:0] tgt;
    logic [NBYTES-1:0][7:0] dat;
    logic [2:0] cnt;
    logic sub;
    logic fast;
    logic busy;
    logic [1:0] raw;
    logic [1:0] msk;
    logic irq;
    logic go_tg;
    logic [2:0] dsy;
    logic [7:0] rdata;
  } tib_core_t;

  typedef struct packed {
    tib_seq_t st;
    logic wait_e;
    logic ph;
    logic [2:0] idx;
    logic err;
    logic [7:0] tgt;
    logic [NBYTES-1:0][7:0] dat;
    logic [2:0] cnt;
    logic sub;
    logic fast;
    logic [2:0] gsy;
    logic done_tg;
    logic [1:0] rsy;
  } tib_link_t;

  tib_core_t core_r, core_nxt;
  tib_link_t link_r, link_nxt;

  logic lnrst;
  logic done_ev;
  logic go_ev;
  logic rd_mode;
  logic e_valid;
  tib_cmd_t e_cmd;
  logic [7:0] e_tx;
  logic e_ack;
  logic e_ready;
  logic e_done;
  logic [7:0] e_rx;
  logic e_rxack;

  // ==========================================================
  // Decode helpers

  function automatic logic is_dat(input logic [7:0] a);
    return (a >= ADR_DAT0) && (a <= ADR_DAT7);
  endfunction : is_dat

  function automatic logic [2:0] dat_idx(input logic [7:0] a);
    return 3'(a - ADR_DAT0);
  endfunction : dat_idx

  function automatic logic [7:0] rd_val(input tib_core_t c, input logic [7:0] a);
    logic [7:0] v;
    v = REG_RST;
    unique case (a)
      ADR_TGT: v = c.tgt;
      ADR_CTL: v = {c.cnt, 2'h0, c.busy, c.sub, c.fast};
      ADR_RAW: v = {6'h00, c.raw};
      ADR_MST: v = {6'h00, c.raw & c.msk};
      ADR_MSK: v = {6'h00, c.msk};
      default: begin
        if (is_dat(a)) begin
          v = c.dat[dat_idx(a)];
        end
      end
    endcase
    return v;
  endfunction : rd_val

  // ==========================================================
  // Core domain: staging registers and status

  assign done_ev = core_r.dsy[2] ^ core_r.dsy[1];

  always_comb begin
    core_nxt = core_r;
    core_nxt.dsy = {core_r.dsy[1:0], link_r.done_tg};
    if (reg_rd) begin
      core_nxt.rdata = rd_val(core_r, reg_addr);
    end
    // Staging is frozen while busy so the link side can read it unsynced
    if (reg_wr) begin
      if (reg_addr == ADR_TGT && !core_r.busy) begin
        core_nxt.tgt = reg_wdata;
      end
      if (is_dat(reg_addr) && !core_r.busy) begin
        core_nxt.dat[dat_idx(reg_addr)] = reg_wdata;
      end
      if (reg_addr == ADR_CTL && !core_r.busy) begin
        core_nxt.cnt = reg_wdata[CTL_CNT_HI:CTL_CNT_LO];
        core_nxt.sub = reg_wdata[CTL_SUB];
        core_nxt.fast = reg_wdata[CTL_FAST];
        if (reg_wdata[CTL_GO]) begin
          core_nxt.busy = 1'b1;
          core_nxt.go_tg = ~core_r.go_tg;
        end
      end
      if (reg_addr == ADR_MSK) begin
        core_nxt.msk = reg_wdata[1:0];
      end
      if (reg_addr == ADR_CLR) begin
        core_nxt.raw = core_r.raw & ~reg_wdata[1:0];
      end
    end
    // Set after clear so an outcome in the clearing cycle survives
    if (done_ev) begin
      core_nxt.busy = 1'b0;
      if (link_r.err) begin
        core_nxt.raw[ST_ERR] = 1'b1;
      end else begin
        core_nxt.raw[ST_DONE] = 1'b1;
      end
      if (core_r.tgt[TGT_DIR] && !link_r.err) begin
        core_nxt.dat = link_r.dat;
      end
    end
    core_nxt.irq = |(core_nxt.raw & core_nxt.msk);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign reg_rdata = core_r.rdata;
  assign host_irq_out = core_r.irq;

  // ==========================================================
  // Link domain: transaction sequencer

  assign lnrst = link_r.rsy[1];
  assign go_ev = link_r.gsy[2] ^ link_r.gsy[1];
  assign rd_mode = link_r.tgt[TGT_DIR];

  // Sole master: nothing watches for lost arbitration
  always_comb begin
    link_nxt = link_r;
    link_nxt.rsy = {link_r.rsy[0], nrst};
    link_nxt.gsy = {link_r.gsy[1:0], core_r.go_tg};
    e_valid = 1'b0;
    e_cmd = TIB_CMD_START;
    e_tx = 8'hff;
    e_ack = 1'b1;
    unique case (link_r.st)
      Q_START: e_cmd = TIB_CMD_START;
      Q_ADDR: begin
        e_cmd = TIB_CMD_BITS;
        e_tx = {link_r.tgt[7:1], rd_mode & link_r.ph};
      end
      Q_DATA: begin
        e_cmd = TIB_CMD_BITS;
        if (rd_mode && link_r.ph) begin
          e_ack = (link_r.idx == link_r.cnt);
        end else begin
          e_tx = link_r.dat[link_r.idx];
        end
      end
      Q_STOP: e_cmd = TIB_CMD_STOP;
      default: ;
    endcase
    if (link_r.st == Q_IDLE && go_ev) begin
      // Core staging is stable from the launch until done returns
      link_nxt.tgt = core_r.tgt;
      link_nxt.dat = core_r.dat;
      link_nxt.cnt = core_r.cnt;
      link_nxt.sub = core_r.sub;
      link_nxt.fast = core_r.fast;
      link_nxt.ph = 1'b0;
      link_nxt.err = 1'b0;
      link_nxt.idx = 3'h0;
      link_nxt.wait_e = 1'b0;
      link_nxt.st = Q_START;
    end
    if (link_r.st != Q_IDLE && !link_r.wait_e && e_ready) begin
      e_valid = 1'b1;
      link_nxt.wait_e = 1'b1;
    end
    if (link_r.wait_e && e_done) begin
      link_nxt.wait_e = 1'b0;
      unique case (link_r.st)
        Q_START: link_nxt.st = Q_ADDR;
        Q_ADDR: begin
          if (e_rxack) begin
            link_nxt.err = 1'b1;
            link_nxt.st = Q_STOP;
          end else if (rd_mode && !link_r.ph) begin
            link_nxt.st = link_r.sub ? Q_DATA : Q_STOP;
          end else begin
            link_nxt.st = Q_DATA;
          end
        end
        Q_DATA: begin
          if (rd_mode && link_r.ph) begin
            link_nxt.dat[link_r.idx] = e_rx;
          end
          if (!(rd_mode && link_r.ph) && e_rxack) begin
            link_nxt.err = 1'b1;
            link_nxt.st = Q_STOP;
          end else if ((rd_mode && !link_r.ph) || link_r.idx == link_r.cnt) begin
            link_nxt.st = Q_STOP;
          end else begin
            link_nxt.idx = 3'(link_r.idx + 3'h1);
          end
        end
        Q_STOP: begin
          if (rd_mode && !link_r.ph && !link_r.err) begin
            link_nxt.ph = 1'b1;
            link_nxt.idx = 3'h0;
            link_nxt.st = Q_START;
          end else begin
            link_nxt.st = Q_IDLE;
            link_nxt.done_tg = ~link_r.done_tg;
          end
        end
        default: ;
      endcase
    end
  end

  // Reset chain keeps shifting while the rest is held
  always_ff @(posedge clk_link) begin
    if (!lnrst) begin
      link_r <= '0;
      link_r.rsy <= link_nxt.rsy;
    end else begin
      link_r <= link_nxt;
    end
  end

  // ==========================================================
  // Bit engine and pins

  tib_bit_eng u_eng (
    .clk_link(clk_link),
    .lnrst(lnrst),
    .cmd_valid(e_valid),
    .cmd(e_cmd),
    .tx_byte(e_tx),
    .ack_bit(e_ack),
    .fast(link_r.fast),
    .ready(e_ready),
    .done(e_done),
    .rx_byte(e_rx),
    .rx_ack(e_rxack),
    .sda_in(tuner_bus_data_line_in),
    .scl_oe_n(tuner_bus_clock_line_oe_n),
    .sda_oe_n(tuner_bus_data_line_oe_n)
  );

  // Open drain: only ever pull low
  assign tuner_bus_clock_line_out = 1'b0;
  assign tuner_bus_data_line_out = 1'b0;

  // ==========================================================
  // Checks

  AST_IRQ_MASKED: assert property (@(posedge clk) disable iff (!nrst)
    (core_r.msk == 2'h0) |-> !host_irq_out)
    else $error("Interrupt raised with all flags masked");

  AST_ERR_NO_DONE: assert property (@(posedge clk) disable iff (!nrst)
    done_ev && link_r.err |=> core_r.raw[ST_ERR] && !$rose(core_r.raw[ST_DONE]))
    else $error("Failed transaction set done or missed error");

  AST_OK_DONE: assert property (@(posedge clk) disable iff (!nrst)
    done_ev && !link_r.err |=> core_r.raw[ST_DONE])
    else $error("Normal end did not set done");

  AST_GO_SELF_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    done_ev |=> !core_r.busy ##1 !done_ev)
    else $error("Start bit stuck after completion");

  AST_STAGE_LOCK: assert property (@(posedge clk) disable iff (!nrst)
    core_r.busy && reg_wr && reg_addr == ADR_TGT |=> $stable(core_r.tgt))
    else $error("Target changed during a transaction");

  AST_READ_FIRST: assert property (@(posedge clk) disable iff (!nrst)
    done_ev && core_r.tgt[TGT_DIR] && !link_r.err |=> core_r.dat[0] == $past(link_r.dat[0]))
    else $error("First read byte not in lowest data register");

  AST_ADDR_DIR: assert property (@(posedge clk_link) disable iff (!lnrst)
    e_valid && link_r.st == Q_ADDR |-> e_tx == {link_r.tgt[7:1], link_r.ph})
    else $error("Wrong direction bit in address byte");

  AST_LAST_NACK: assert property (@(posedge clk_link) disable iff (!lnrst)
    e_valid && link_r.st == Q_DATA && rd_mode && link_r.ph
      |-> e_ack == (link_r.idx == link_r.cnt) && e_tx == 8'hff)
    else $error("Acknowledge wrong on received byte");

  AST_NACK_STOP: assert property (@(posedge clk_link) disable iff (!lnrst)
    link_r.wait_e && e_done && link_r.st == Q_ADDR && e_rxack
      |=> link_r.st == Q_STOP && link_r.err)
    else $error("Address not acknowledged but no stop");

  COV_WRITE_OK: cover property (@(posedge clk) disable iff (!nrst)
    done_ev && !core_r.tgt[TGT_DIR] && !link_r.err);
  COV_READ_OK: cover property (@(posedge clk) disable iff (!nrst)
    done_ev && core_r.tgt[TGT_DIR] && !link_r.err);
  COV_ERROR: cover property (@(posedge clk) disable iff (!nrst)
    done_ev && link_r.err);

endmodule : tib_bridge

// File: verif/tib_tuner_model.sv
// Tuner model: two-wire slave that answers one address, open drain.
// Assumes the bench joins both lines with pull-ups; never drives clock.
module tib_tuner_model #(
  parameter logic [6:0] ADDR_P = 7'h61
) (
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe_n,
  // Fault control: data byte index to refuse
  input wire logic [3:0] nack_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh, tx;
  logic [7:0] got[$];
  logic [3:0] bit_cnt, idx;
  logic rd, match, mack, txon;
  int n_start, n_stop, n_mack, n_mnack;
  time t_rise, per;
  initial begin
    sda_oe_n = 1'b1;
    bit_cnt = 4'h0;
    idx = 4'h0;
    txon = 1'b0;
  end
  // ==========================================
  // Framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      n_start++;
      // Clock fall that closes the start wraps this to zero
      bit_cnt = 4'hf;
      idx = 4'h0;
      rd = 1'b0;
      txon = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) n_stop++;
  end
  // ==========================================
  // Bits; only this end answers, so no arbitration
  always @(posedge scl) begin
    if (bit_cnt > 4'h0 && bit_cnt < 4'h8) per = $time - t_rise;
    t_rise = $time;
    if (bit_cnt < 4'h8) sh = {sh[6:0], sda};
    else if (rd && match && idx != 4'h0) begin
      mack = sda;
      if (sda) n_mnack++;
      else n_mack++;
    end
  end
  // Changes land 50 ns after clock fall to keep data hold
  always @(negedge scl) begin
    bit_cnt = bit_cnt + 4'h1;
    if (bit_cnt == 4'h8) begin
      if (idx == 4'h0) begin
        rd = sh[0];
        match = (sh[7:1] == ADDR_P);
      end else if (!rd) got.push_back(sh);
      if (idx == 4'h0 || !rd) sda_oe_n <= #50 !(match && idx != nack_idx);
      else sda_oe_n <= #50 1'b1;
    end else if (bit_cnt == 4'h9) begin
      bit_cnt = 4'h0;
      idx = idx + 4'h1;
      txon = rd && match && (idx == 4'h1 || !mack);
      tx = 8'hc0 + {4'h0, idx};
      sda_oe_n <= #50 !txon | tx[7];
    end else if (txon) sda_oe_n <= #50 tx[3'h7 - bit_cnt[2:0]];
  end
endmodule : tib_tuner_model

// File: verif/tib_bridge_test.sv
// Bench for the tuner bus bridge: register tasks plus a tuner model.
// Assumes pull-ups on both lines, resolved here from all enables.
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tib_bridge_test
  import tib_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] TADR = 7'h61;
  logic clk, nrst, clk_link, reg_wr, reg_rd, host_irq_out, scl_oe_n, sda_oe_n, mdl_oe_n;
  logic scl_o, sda_o;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [3:0] nack_idx;
  wire logic scl_w, sda_w;
  int n_mismatch, n_checks, s0, p0, a0, k0;
  logic [7:0] rmap [9] = '{ADR_TGT, ADR_DAT0, ADR_DAT7, ADR_CTL, ADR_RAW, ADR_MST,
                           ADR_MSK, ADR_CLR, 8'h20};
  // Pull-ups: a line is high unless an enabled driver pulls it
  assign scl_w = scl_oe_n ? 1'b1 : scl_o;
  assign sda_w = (sda_oe_n ? 1'b1 : sda_o) & mdl_oe_n;
  tib_bridge DUT (.clk(clk), .nrst(nrst), .clk_link(clk_link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .host_irq_out(host_irq_out), .tuner_bus_clock_line_out(scl_o),
    .tuner_bus_clock_line_oe_n(scl_oe_n), .tuner_bus_data_line_in(sda_w),
    .tuner_bus_data_line_out(sda_o), .tuner_bus_data_line_oe_n(sda_oe_n));
  tib_tuner_model #(.ADDR_P(TADR)) u_tuner (.scl(scl_w), .sda(sda_w),
    .sda_oe_n(mdl_oe_n), .nack_idx(nack_idx));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    clk_link = 1'b0;
    #3;
    forever #6 clk_link = ~clk_link;
  end
  // ==========================================
  // Register access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    `CHK(v, e)
  endtask : chk
  task automatic go(input logic [7:0] tgt, input logic [7:0] ctl);
    wr(ADR_TGT, tgt);
    u_tuner.got.delete();
    s0 = u_tuner.n_start;
    p0 = u_tuner.n_stop;
    a0 = u_tuner.n_mack;
    k0 = u_tuner.n_mnack;
    wr(ADR_CTL, ctl);
  endtask : go
  // Host polls busy; bounded so a hang shows as a mismatch
  task automatic wait_idle();
    int i;
    i = 0;
    v = 8'hff;
    while (v[CTL_GO] !== 1'b0 && i < 20000) begin
      rd(ADR_CTL, v);
      i++;
    end
    `CHK(v[CTL_GO], 1'b0)
  endtask : wait_idle
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  initial begin
    #2_000_000;
    n_mismatch++;
    end_sim();
  end
  // ==========================================
  // Scenarios
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nack_idx = 4'hf;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    wr(8'h20, 8'h5a);
    foreach (rmap[i]) chk(rmap[i], 8'h00);
    // Fast write of three bytes, interrupt enabled
    wr(ADR_MSK, 8'h03);
    for (int i = 0; i < 3; i++) wr(ADR_DAT0 + 8'(i), 8'h11 * 8'(i + 1));
    go({TADR, 1'b0}, 8'h45);
    chk(ADR_CTL, 8'h45);
    wr(ADR_DAT0, 8'hee);
    wait_idle();
    chk(ADR_DAT0, 8'h11);
    for (int i = 0; i < 3; i++) `CHK(u_tuner.got[i], 8'h11 * 8'(i + 1))
    `CHK(u_tuner.got.size(), 3)
    `CHK(u_tuner.n_start - s0, 1)
    `CHK(u_tuner.n_stop - p0, 1)
    `CHK(u_tuner.per / 48, QTR_FAST)
    chk(ADR_RAW, 8'h01);
    chk(ADR_MST, 8'h01);
    `CHK(host_irq_out, 1'b1)
    wr(ADR_CLR, 8'h03);
    chk(ADR_RAW, 8'h00);
    `CHK(host_irq_out, 1'b0)
    // Standard rate, one byte, interrupt masked and polled
    wr(ADR_MSK, 8'h00);
    go({TADR, 1'b0}, 8'h04);
    wait_idle();
    `CHK(u_tuner.got[0], 8'h11)
    `CHK(u_tuner.per / 48, QTR_STD)
    chk(ADR_MST, 8'h00);
    chk(ADR_RAW, 8'h01);
    `CHK(host_irq_out, 1'b0)
    wr(ADR_CLR, 8'h01);
    // Eight-byte read after a subaddress phase
    wr(ADR_DAT0, 8'h5a);
    go({TADR, 1'b1}, 8'he7);
    wait_idle();
    `CHK(u_tuner.got[0], 8'h5a)
    `CHK(u_tuner.got.size(), 1)
    `CHK(u_tuner.n_start - s0, 2)
    `CHK(u_tuner.n_stop - p0, 2)
    `CHK(u_tuner.n_mack - a0, 7)
    `CHK(u_tuner.n_mnack - k0, 1)
    for (int i = 0; i < 8; i++) chk(ADR_DAT0 + 8'(i), 8'hc1 + 8'(i));
    chk(ADR_RAW, 8'h01);
    wr(ADR_CLR, 8'h01);
    // Refused address, error interrupt enabled
    wr(ADR_MSK, 8'h02);
    go({TADR ^ 7'h01, 1'b0}, 8'h05);
    wait_idle();
    `CHK(u_tuner.got.size(), 0)
    `CHK(u_tuner.n_stop - p0, 1)
    chk(ADR_RAW, 8'h02);
    `CHK(host_irq_out, 1'b1)
    wr(ADR_CLR, 8'h02);
    // Second data byte refused in mid write
    nack_idx <= 4'h2;
    go({TADR, 1'b0}, 8'h65);
    wait_idle();
    `CHK(u_tuner.got.size(), 2)
    `CHK(u_tuner.n_stop - p0, 1)
    chk(ADR_RAW, 8'h02);
    nack_idx <= 4'hf;
    end_sim();
  end
endmodule : tib_bridge_test
